// >>> rtl/scxed_regs.svh
// register map and field layout of the signal crossbar with edge detect
// assumes a 16-bit register port with an 8-bit word address
`ifndef SCXED_REGS_SVH
`define SCXED_REGS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define SCX_SEL_BASE  8'h00
`define SCX_SEL_LAST  8'h07
`define SCX_CTRL_LO   8'h10
`define SCX_CTRL_HI   8'h11
`define SCX_STATUS    8'h12
`define SCX_CLEAR     8'h13
`define SCX_ENABLE    8'h14

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SCX_MODE_LSB  0
`define SCX_EDGE_LSB  2
`define SCX_STS_BIT   4
`define SCX_LANE_W    8
`define SCX_SEL_RST   4'h0
`define SCX_ENA_RST   4'h0
`define SCX_ZERO16    16'h0000

`endif

// >>> rtl/scxed_pkg.sv
// types and sizes shared by the crossbar design
// assumes nothing beyond the register header
package scxed_pkg;

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int SCX_NIN  = 16;
   localparam int SCX_NOUT = 8;
   localparam int SCX_NEDG = 4;
   localparam int SCX_SELW = 4;

   // ----------------------------------------
   // configuration encodings
   // ----------------------------------------
   typedef enum logic [1:0] {
      SCX_EDGE_NONE,
      SCX_EDGE_RISE,
      SCX_EDGE_FALL,
      SCX_EDGE_BOTH
   } scx_edge_e;

   typedef enum logic [1:0] {
      SCX_REQ_OFF,
      SCX_REQ_DMA,
      SCX_REQ_IRQ,
      SCX_REQ_RSVD
   } scx_req_e;

endpackage

// >>> rtl/scxed_top.sv
// signal crossbar: each output picks one input; outputs 0..3 also
// detect a chosen edge and raise a dma or interrupt request
// assumes inputs synchronous to sys_clk and a clock that software
// ungates before configuring the block
//
// Notes on behaviour
// - each output is driven by one software-selected input of this crossbar
// - edge setting per edge output: none, rising, falling, or both
// - request setting per edge output: off, dma only, or interrupt only
// - with a request enabled, status reads one exactly while request asserted
// - outputs zero to three each own a flag set by their active edge
// - only outputs zero to three have edge and request control fields
// - a clear mask write clears any chosen set of flags at once, except a flag whose edge hits in that same cycle
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps

`include "scxed_regs.svh"

module scxed_top
   import scxed_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 reset,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [15:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [15:0]          reg_rdata,
   input  wire logic [SCX_NIN-1:0]   trig_in,
   output logic      [SCX_NOUT-1:0]  trig_out,
   output logic      [SCX_NEDG-1:0]  dma_req,
   output logic      [SCX_NEDG-1:0]  irq_req,
   output logic                      irq
);

   // ----------------------------------------
   // helper functions
   // ----------------------------------------

   // true when the configured edge shows between two samples
   function automatic logic edge_hit(
      input scx_edge_e mode,
      input logic      prev,
      input logic      cur
   );
      logic rise;
      logic fall;
      rise = !prev && cur;
      fall = prev && !cur;
      case (mode)
         SCX_EDGE_NONE: edge_hit = 1'b0;
         SCX_EDGE_RISE: edge_hit = rise;
         SCX_EDGE_FALL: edge_hit = fall;
         SCX_EDGE_BOTH: edge_hit = rise || fall;
         default:       edge_hit = 1'b0;
      endcase
   endfunction

   // true for an address inside the select window
   function automatic logic in_sel(
      input logic [7:0] addr
   );
      in_sel = (addr >= `SCX_SEL_BASE) && (addr <= `SCX_SEL_LAST);
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic      [SCX_SELW-1:0]  sel     [SCX_NOUT];
   scx_edge_e                 edge_cfg[SCX_NEDG];
   scx_req_e                  req_cfg [SCX_NEDG];
   logic      [SCX_NEDG-1:0]  flag;
   logic      [SCX_NEDG-1:0]  irq_ena;
   logic      [SCX_NEDG-1:0]  prev_out;

   // ----------------------------------------
   // address decode
   // ----------------------------------------

   // one strobe per register group
   wire        sel_wr  = reg_wr && in_sel(reg_addr);
   wire        lo_wr   = reg_wr && (reg_addr == `SCX_CTRL_LO);
   wire        hi_wr   = reg_wr && (reg_addr == `SCX_CTRL_HI);
   wire        clr_wr  = reg_wr && (reg_addr == `SCX_CLEAR);
   wire        ena_wr  = reg_wr && (reg_addr == `SCX_ENABLE);
   wire [2:0]  sel_idx = reg_addr[2:0];

   // ----------------------------------------
   // input select registers and crossbar
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < SCX_NOUT; g++) begin : g_out
         wire sel_me = sel_wr && (sel_idx == 3'(g));

         // select field, written through its own register
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               sel[g] <= `SCX_SEL_RST;
            end else if (sel_me) begin
               sel[g] <= reg_wdata[SCX_SELW-1:0];
            end
         end

         // routed output, one register stage
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               trig_out[g] <= 1'b0;
            end else begin
               trig_out[g] <= trig_in[sel[g]];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // edge detect and request logic
   // ----------------------------------------
   wire [SCX_NEDG-1:0] next_flag;
   wire [SCX_NEDG-1:0] next_dma;
   wire [SCX_NEDG-1:0] next_irq;
   wire [SCX_NEDG-1:0] next_ena;

   // clear mask and enable take the low bits of the word
   wire [SCX_NEDG-1:0] clr_mask = clr_wr ?
                                  reg_wdata[SCX_NEDG-1:0] :
                                  {SCX_NEDG{1'b0}};
   assign next_ena = ena_wr ? reg_wdata[SCX_NEDG-1:0] : irq_ena;

   genvar k;
   generate
      for (k = 0; k < SCX_NEDG; k++) begin : g_edge
         // two outputs share one control register, one byte each
         localparam int LANE = (k % 2) * `SCX_LANE_W;
         wire       ctl_wr = (k < 2) ? lo_wr : hi_wr;
         wire [7:0] wbyte  = reg_wdata[LANE +: `SCX_LANE_W];

         // configuration after this cycle's write
         wire scx_edge_e next_edge = ctl_wr ?
              scx_edge_e'(wbyte[`SCX_EDGE_LSB +: 2]) :
              edge_cfg[k];
         wire scx_req_e  next_req  = ctl_wr ?
              scx_req_e'(wbyte[`SCX_MODE_LSB +: 2]) :
              req_cfg[k];

         // edge seen on the routed output
         wire hit = edge_hit(edge_cfg[k], prev_out[k], trig_out[k]);

         // write-one on the control bit or the clear mask
         wire clr_one = ctl_wr && wbyte[`SCX_STS_BIT];
         wire clr_any = clr_one || clr_mask[k];

         // a new edge wins over a clear in the same cycle
         assign next_flag[k] = hit || (flag[k] && !clr_any);

         // requests follow the flag directly
         assign next_dma[k] = next_flag[k] &&
                              (next_req == SCX_REQ_DMA);
         assign next_irq[k] = next_flag[k] &&
                              (next_req == SCX_REQ_IRQ);

         // edge and request configuration
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               edge_cfg[k] <= SCX_EDGE_NONE;
               req_cfg[k]  <= SCX_REQ_OFF;
            end else begin
               edge_cfg[k] <= next_edge;
               req_cfg[k]  <= next_req;
            end
         end
      end
   endgenerate

   // previous output sample for edge compare
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         prev_out <= {SCX_NEDG{1'b0}};
      end else begin
         prev_out <= trig_out[SCX_NEDG-1:0];
      end
   end

   // sticky flags and the requests they drive
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         flag    <= {SCX_NEDG{1'b0}};
         dma_req <= {SCX_NEDG{1'b0}};
         irq_req <= {SCX_NEDG{1'b0}};
      end else begin
         flag    <= next_flag;
         dma_req <= next_dma;
         irq_req <= next_irq;
      end
   end

   // ----------------------------------------
   // interrupt enable and summary output
   // ----------------------------------------

   // level output while any enabled flag stands
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_ena <= `SCX_ENA_RST;
         irq     <= 1'b0;
      end else begin
         irq_ena <= next_ena;
         irq     <= |(next_flag & next_ena);
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------

   // control byte of one edge output
   function automatic logic [7:0] ctl_byte(
      input scx_edge_e e,
      input scx_req_e  r,
      input logic      f
   );
      ctl_byte                          = 8'h00;
      ctl_byte[`SCX_MODE_LSB +: 2]      = r;
      ctl_byte[`SCX_EDGE_LSB +: 2]      = e;
      ctl_byte[`SCX_STS_BIT]            = f;
   endfunction

   // words of each readable register
   wire [15:0] ctl_lo  = {ctl_byte(edge_cfg[1], req_cfg[1], flag[1]),
                          ctl_byte(edge_cfg[0], req_cfg[0], flag[0])};
   wire [15:0] ctl_hi  = {ctl_byte(edge_cfg[3], req_cfg[3], flag[3]),
                          ctl_byte(edge_cfg[2], req_cfg[2], flag[2])};
   wire [15:0] sel_rd  = {12'h000, sel[sel_idx]};
   wire [15:0] sts_rd  = {12'h000, flag};
   wire [15:0] ena_rd  = {12'h000, irq_ena};

   // unmapped and write-only addresses read zero
   wire [15:0] rd_word =
      in_sel(reg_addr)               ? sel_rd :
      (reg_addr == `SCX_CTRL_LO)     ? ctl_lo :
      (reg_addr == `SCX_CTRL_HI)     ? ctl_hi :
      (reg_addr == `SCX_STATUS)      ? sts_rd :
      (reg_addr == `SCX_ENABLE)      ? ena_rd :
                                       `SCX_ZERO16;

   // read data valid only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= `SCX_ZERO16;
      end else if (reg_rd) begin
         reg_rdata <= rd_word;
      end else begin
         reg_rdata <= `SCX_ZERO16;
      end
   end

endmodule

// >>> tb/scxed_monitor.sv
// checker for the crossbar register port and request outputs
// assumes it sees only the ports of scxed_top, bound below
`timescale 1ns/100ps
`include "scxed_regs.svh"
module scxed_monitor
   import scxed_pkg::*;
(
   input wire logic                sys_clk,
   input wire logic                reset,
   input wire logic [7:0]          reg_addr,
   input wire logic [15:0]         reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [15:0]         reg_rdata,
   input wire logic [SCX_NIN-1:0]  trig_in,
   input wire logic [SCX_NOUT-1:0] trig_out,
   input wire logic [SCX_NEDG-1:0] dma_req,
   input wire logic [SCX_NEDG-1:0] irq_req,
   input wire logic                irq
);
   // all checks on the one clock, off during reset
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_req_excl: assert property ((dma_req & irq_req) == 4'h0)
      else $error("dma and irq request together");
   a_req_cause: assert property ($rose(dma_req[0]) |-> $past(reg_wr) || $past(trig_out[0]) != $past(trig_out[0], 2))
      else $error("request rose without edge");
   a_req_hold: assert property (dma_req[0] && !reg_wr |=> dma_req[0])
      else $error("request dropped on its own");
   a_clr_drop: assert property (reg_wr && reg_addr == `SCX_CLEAR && reg_wdata[0] && $stable(trig_out[0])
      |=> !dma_req[0] && !irq_req[0])
      else $error("clear left request up");
   a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
   a_clr_rd: assert property (reg_rd && reg_addr == `SCX_CLEAR |=> reg_rdata == 16'h0000)
      else $error("clear mask reads nonzero");
   a_sts_rd: assert property (reg_rd && reg_addr == `SCX_STATUS |=> reg_rdata[15:4] == 12'h000)
      else $error("status has extra flags");
   a_unmap_rd: assert property (reg_rd && reg_addr > `SCX_ENABLE |=> reg_rdata == 16'h0000)
      else $error("unmapped read nonzero");
endmodule

bind scxed_top scxed_monitor u_scxed_monitor (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .trig_in, .trig_out, .dma_req, .irq_req, .irq);

// >>> tb/scxed_periph.sv
// peripheral trigger sources feeding the crossbar inputs
// assumes the bench sets the wanted levels on pattern
`timescale 1ns/100ps
module scxed_periph
   import scxed_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               reset,
   input  wire logic [SCX_NIN-1:0] pattern,
   output logic      [SCX_NIN-1:0] trig_in
);
   // sources launch levels from their own flops on sys_clk
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         trig_in <= '0;
      end else begin
         trig_in <= pattern;
      end
   end
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the signal crossbar with edge detect
// assumes scxed_periph drives trig_in and the monitor is bound in
`timescale 1ns/100ps
`include "scxed_regs.svh"
module tb_top import scxed_pkg::*;;
   logic        sys_clk, reset, reg_wr, reg_rd, irq;
   logic [7:0]  reg_addr, trig_out;
   logic [15:0] reg_wdata, reg_rdata, pat, trig_in, v;
   logic [3:0]  dma_req, irq_req;
   int          err_count, checks_done, cycles;

   scxed_top u_scxed_top (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .trig_in, .trig_out, .dma_req, .irq_req, .irq);
   scxed_periph u_scxed_periph (.sys_clk, .reset, .pattern(pat), .trig_in);

   // clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         end_of_test();
      end
   end

   function automatic logic [15:0] rv();
      return {7'h00, dma_req, irq_req, irq};
   endfunction
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic drive(input logic [15:0] p);
      @(posedge sys_clk);
      pat <= p;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask

   // reset values, write-only and unmapped places
   task automatic t_reset;
      rd(`SCX_SEL_BASE); chk(v, 16'h0000);
      rd(`SCX_CTRL_LO); chk(v, 16'h0000);
      rd(`SCX_STATUS); chk(v, 16'h0000);
      rd(`SCX_CLEAR); chk(v, 16'h0000);
      rd(8'h20); chk(v, 16'h0000);
   endtask
   // every output picks a different input
   task automatic t_route;
      logic [7:0] e;
      for (int g = 0; g < 8; g++) wr(`SCX_SEL_BASE + 8'(g), 16'(2 * g + 1));
      drive(16'hA5C3);
      for (int g = 0; g < 8; g++) e[g] = pat[2 * g + 1];
      chk({8'h00, trig_out}, {8'h00, e});
   endtask
   // each edge setting, dma on output 0, interrupt on output 1
   task automatic t_edge;
      logic [1:0] ed;
      wr(`SCX_SEL_BASE, 16'h0000);
      wr(`SCX_SEL_BASE + 8'h01, 16'h0000);
      wr(`SCX_ENABLE, 16'h0002);
      drive(16'h0000);
      for (int e = 0; e < 4; e++) begin
         ed = e[1:0];
         wr(`SCX_CTRL_LO, {4'h0, ed, SCX_REQ_IRQ, 4'h0, ed, SCX_REQ_DMA});
         drive(16'h0001);
         chk(rv(), ed[0] ? 16'h0025 : 16'h0000);
         rd(`SCX_STATUS); chk(v, ed[0] ? 16'h0003 : 16'h0000);
         wr(`SCX_CLEAR, 16'h0003); chk(rv(), 16'h0000);
         drive(16'h0000);
         chk(rv(), ed[1] ? 16'h0025 : 16'h0000);
         wr(`SCX_CLEAR, 16'h0001); chk(rv(), ed[1] ? 16'h0005 : 16'h0000);
         wr(`SCX_CLEAR, 16'h0002);
      end
   endtask
   // masked interrupt, requests off, clear through the control byte
   task automatic t_mask;
      wr(`SCX_ENABLE, 16'h0000);
      drive(16'h0001);
      chk(rv(), 16'h0024);
      wr(`SCX_CTRL_LO, {4'h0, SCX_EDGE_BOTH, SCX_REQ_OFF, 4'h0, SCX_EDGE_BOTH, SCX_REQ_OFF});
      chk(rv(), 16'h0000);
      rd(`SCX_CTRL_LO); chk(v, 16'h1C1C);
      wr(`SCX_CTRL_LO, 16'h0C1C);
      rd(`SCX_STATUS); chk(v, 16'h0002);
      wr(`SCX_CLEAR, 16'h0002);
      wr(`SCX_CTRL_HI, 16'hFFFF);
      rd(`SCX_CTRL_HI); chk(v, 16'h0F0F);
      // output 2 sees a rise on input 5, outputs 0 and 1 a fall; no request
      drive(16'h0020);
      rd(`SCX_STATUS); chk(v, 16'h0007);
      chk(rv(), 16'h0000);
   endtask

   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // reset, then setup only once the block is clocked and out of reset
   initial begin
      {pat, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      reset = 1'b1;
      err_count = 0;
      checks_done = 0;
      cycles = 0;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset;
      t_route;
      t_edge;
      t_mask;
      end_of_test;
   end
endmodule
